// File: design/nvu_pkg.sv
/*
 nvu_pkg: register offsets, bit positions, key values, eeprom map,
 operation codes, timing counts and state types of the nvm controller.
 Assumes a 100 MHz core clock.
*/
package nvu_pkg;
   // register byte offsets
   localparam logic [15:0] NVU_CONTROL_OFS    = 16'h0760;
   localparam logic [15:0] NVU_ADDR_LOW_OFS   = 16'h0762;
   localparam logic [15:0] NVU_ADDR_UPPER_OFS = 16'h0764;
   localparam logic [15:0] NVU_KEY_OFS        = 16'h0766;
   // control bit positions and reset values
   localparam int NVU_WR_BIT    = 15;
   localparam int NVU_WRITE_PERMIT_BIT  = 14;
   localparam int NVU_WRITE_ABORT_ERROR_BIT = 13;
   localparam int NVU_OPSEL_W   = 7;
   localparam logic [15:0] NVU_CONTROL_RST = 16'h0000;
   localparam logic [7:0]  NVU_UPPER_HI    = 8'h00;
   // unlock keys
   localparam logic [7:0] NVU_KEY_FIRST  = 8'h55;
   localparam logic [7:0] NVU_KEY_SECOND = 8'haa;
   // eeprom map: word addresses 0x7ffc00 .. 0x7ffffe
   localparam logic [23:0] NVU_EE_BASE  = 24'h7ffc00;
   localparam logic [23:0] NVU_EE_LAST  = 24'h7ffffe;
   localparam int          NVU_EE_WORDS = 512;
   localparam int          NVU_EE_IDX_W = 9;
   localparam int          NVU_BLK_WORDS = 16;
   localparam int          NVU_BLK_W     = 4;
   localparam logic [15:0] NVU_ERASED    = 16'hffff;
   // operation select: bit 6 erase, low nibble target
   localparam int         NVU_OP_ERASE_BIT = 6;
   localparam logic [3:0] NVU_OP_FLASH_ROW = 4'h1;
   localparam logic [3:0] NVU_OP_EE_WORD   = 4'h4;
   localparam logic [3:0] NVU_OP_EE_BLOCK  = 4'h5;
   // timing
   localparam int unsigned NVU_CLK_PERIOD_NS   = 10;
   localparam int unsigned NVU_EE_WRITE_TIME_MS = 2;
   localparam int unsigned NVU_FL_WRITE_TIME_MS = 2;
   localparam int unsigned NVU_EE_WRITE_CYCLES =
      (NVU_EE_WRITE_TIME_MS * 1000000 + NVU_CLK_PERIOD_NS - 1)
      / NVU_CLK_PERIOD_NS;
   localparam int unsigned NVU_FL_WRITE_CYCLES =
      (NVU_FL_WRITE_TIME_MS * 1000000 + NVU_CLK_PERIOD_NS - 1)
      / NVU_CLK_PERIOD_NS;
   localparam int NVU_TMR_W = 18;
   // states
   typedef enum logic [1:0] {ST_IDLE, ST_EE_BUSY, ST_FL_BUSY} nvu_state_e;
   typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST_SEEN, KEY_ARMED} nvu_key_e;

   // eeprom window hit
   function automatic logic nvu_is_ee(input logic [23:0] ea);
      nvu_is_ee = (ea >= NVU_EE_BASE) && (ea <= NVU_EE_LAST);
   endfunction

   // word index inside the eeprom
   function automatic logic [NVU_EE_IDX_W-1:0] nvu_ee_idx(
      input logic [23:0] ea);
      nvu_ee_idx = ea[NVU_EE_IDX_W:1];
   endfunction
endpackage

// File: design/nvu_op_timer.sv
/*
 nvu_op_timer: down-counter timing one erase or program operation.
 Assumes start is only raised while idle; abort stops it at once.
*/
`timescale 1ns/10ps
module nvu_op_timer
   import nvu_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 resetn,
   input  wire logic                 clk_en,
   input  wire logic                 start,
   input  wire logic                 abort,
   input  wire logic [NVU_TMR_W-1:0] load,
   output logic                      busy,
   output logic                      done
);
   logic [NVU_TMR_W-1:0] cnt_q;

   // count down, done in the last cycle
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         cnt_q <= '0;
      else if (clk_en)
      begin
         if (abort)
            cnt_q <= '0;
         else if (start)
            cnt_q <= load;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = clk_en && !abort && (cnt_q == {{(NVU_TMR_W-1){1'b0}}, 1'b1});

   a_timer_ends_idle: assert property ( // [R9]
      @(posedge ref_clk) disable iff (!resetn)
      done |=> !busy) else $error("timer still busy after done");
endmodule

// File: design/nvu_unlock.sv
/*
 nvu_unlock: tracks the two-key unlock sequence written to the key
 register. Assumes one register or table write per cycle at most.
*/
`timescale 1ns/10ps
module nvu_unlock
   import nvu_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   input  wire logic       soft_clear,
   input  wire logic       any_write,
   input  wire logic       key_write,
   input  wire logic [7:0] key_data,
   output logic            unlock_ok
);
   nvu_key_e stage_q;

   // any write other than the expected key or the first key breaks the sequence
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         stage_q <= KEY_IDLE;
      else if (clk_en)
      begin
         if (soft_clear)
            stage_q <= KEY_IDLE;
         else if (any_write)
         begin
            if (key_write && key_data == NVU_KEY_FIRST)
               stage_q <= KEY_FIRST_SEEN; // [R1]
            else if (key_write && key_data == NVU_KEY_SECOND &&
                     stage_q == KEY_FIRST_SEEN)
               stage_q <= KEY_ARMED; // [R1]
            else
               stage_q <= KEY_IDLE; // [R23]
         end
      end
   end

   assign unlock_ok = (stage_q == KEY_ARMED);

   a_key_order: assert property ( // [R1]
      @(posedge ref_clk) disable iff (!resetn)
      $rose(unlock_ok) |-> $past(key_write && key_data == NVU_KEY_SECOND))
      else $error("armed without second key");
endmodule

// File: design/nvu_ctrl.sv
/*
 nvu_ctrl: nonvolatile memory unlock and eeprom controller with its four
 control registers, table access port and an in-block eeprom array.
 Assumes single-cycle register and table strobes from the core, and
 reset-cause pulses synchronous to ref_clk.
*/
// Functional notes
// R1 - start needs keys 0x55 then 0xaa first
// R2 - software puts two nops after start
// R3 - software masks interrupts below 7 meanwhile
// R4 - software waits the full programming time
// R5 - eeprom mapped at 0x7ffc00 to 0x7ffffe
// R6 - erase and write single word or 16
// R7 - target address from low and upper registers
// R8 - software erases before writing a word
// R9 - eeprom write takes about 2 ms
// R10 - eeprom operations never stall the core
// R11 - software waits before next eeprom operation
// R12 - eeprom read while busy gives unspecified data
// R13 - write start settable only, hardware clears
// R14 - write permit gates start, clear at power-up
// R15 - reset during write sets abort error
// R16 - low address survives reset during write
// R17 - done flag set on completion, software clears
// R18 - eeprom reached through table read/write low
// R19 - resets clear control and key registers
// R20 - software writes both keys back to back
// R21 - flash operation stalls core, then clears start
// R22 - address registers capture last table address
// R23 - other write discards a partial unlock
`timescale 1ns/10ps
module nvu_ctrl
   import nvu_pkg::*;
#(
   parameter int unsigned EE_WRITE_CYCLES = NVU_EE_WRITE_CYCLES,
   parameter int unsigned FL_WRITE_CYCLES = NVU_FL_WRITE_CYCLES
)
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        master_clear_reset,
   input  wire logic        watchdog_timer_timeout,
   input  wire logic [15:0] sfr_addr,
   input  wire logic        sfr_wr_en,
   input  wire logic        sfr_rd_en,
   input  wire logic [15:0] sfr_wdata,
   output logic      [15:0] sfr_rdata,
   input  wire logic        tbl_valid,
   input  wire logic        tbl_write,
   input  wire logic [23:0] tbl_ea,
   input  wire logic [15:0] tbl_wdata,
   output logic      [15:0] tbl_rdata,
   output logic             tbl_rvalid,
   input  wire logic        memory_op_done_clear,
   output logic             memory_op_done_flag,
   output logic             cpu_stall
);
   // register state
   logic                   write_start_q;
   logic                   write_permit_q;
   logic                   write_abort_error_q;
   logic [NVU_OPSEL_W-1:0] operation_select_q;
   logic [15:0]            addr_low_q;
   logic [7:0]             addr_upper_q;
   nvu_state_e             state_q;
   logic                   done_flag_q;
   logic [15:0]            sfr_rdata_q;
   logic [15:0]            tbl_rdata_q;
   logic                   tbl_rvalid_q;
   // operation latched at start
   logic                   op_erase_q;
   logic                   op_block_q;
   logic [NVU_EE_IDX_W-1:0] op_idx_q;
   // storage
   logic [15:0]            ee_mem   [NVU_EE_WORDS];
   logic [15:0]            ee_latch [NVU_BLK_WORDS];
   // decode and control
   logic                   soft_rst;
   logic                   wr_ctrl;
   logic                   wr_low;
   logic                   wr_upper;
   logic                   wr_key;
   logic                   any_write;
   logic                   unlock_ok;
   logic [23:0]            target_ea;
   logic [3:0]             new_target;
   logic                   new_is_ee;
   logic                   new_is_flash;
   logic                   start_op;
   logic [NVU_TMR_W-1:0]   tmr_load;
   logic                   op_done;
   logic                   tbl_ee_hit;
   logic [NVU_EE_IDX_W-1:0] tbl_idx;

   // reset causes that abort an operation but keep the address
   assign soft_rst = master_clear_reset | watchdog_timer_timeout;

   // register address decode
   assign wr_ctrl  = sfr_wr_en && (sfr_addr == NVU_CONTROL_OFS);
   assign wr_low   = sfr_wr_en && (sfr_addr == NVU_ADDR_LOW_OFS);
   assign wr_upper = sfr_wr_en && (sfr_addr == NVU_ADDR_UPPER_OFS);
   assign wr_key   = sfr_wr_en && (sfr_addr == NVU_KEY_OFS);
   assign any_write = sfr_wr_en | (tbl_valid & tbl_write);

   // target location from both address registers
   assign target_ea = {addr_upper_q, addr_low_q}; // [R7]

   // decode the operation that the control write asks for
   assign new_target   = sfr_wdata[3:0];
   assign new_is_flash = (new_target == NVU_OP_FLASH_ROW);
   assign new_is_ee    = ((new_target == NVU_OP_EE_WORD) ||
                          (new_target == NVU_OP_EE_BLOCK)) &&
                         nvu_is_ee(target_ea);

   // start needs keys, permit bit, idle block and a known operation
   assign start_op = clk_en && wr_ctrl && !soft_rst &&
                     sfr_wdata[NVU_WR_BIT] &&
                     sfr_wdata[NVU_WRITE_PERMIT_BIT] && // [R14]
                     unlock_ok && // [R1]
                     (state_q == ST_IDLE) &&
                     (new_is_flash || new_is_ee);

   assign tmr_load = new_is_flash ? NVU_TMR_W'(FL_WRITE_CYCLES)
                                  : NVU_TMR_W'(EE_WRITE_CYCLES); // [R9]

   // table port decode
   assign tbl_ee_hit = nvu_is_ee(tbl_ea); // [R5]
   assign tbl_idx    = nvu_ee_idx(tbl_ea);

   nvu_unlock u_unlock
   (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .clk_en     (clk_en),
      .soft_clear (soft_rst),
      .any_write  (any_write),
      .key_write  (wr_key),
      .key_data   (sfr_wdata[7:0]),
      .unlock_ok  (unlock_ok)
   );

   nvu_op_timer u_timer
   (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .start   (start_op),
      .abort   (soft_rst),
      .load    (tmr_load),
      .busy    (),
      .done    (op_done)
   );

   // operation state: flash busy stalls, eeprom busy runs in background
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         state_q <= ST_IDLE;
      else if (clk_en)
      begin
         if (soft_rst || op_done)
            state_q <= ST_IDLE;
         else if (start_op)
            state_q <= new_is_flash ? ST_FL_BUSY : ST_EE_BUSY;
      end
   end

   // write start bit: software sets, only hardware clears
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         write_start_q <= NVU_CONTROL_RST[NVU_WR_BIT];
      else if (clk_en)
      begin
         if (soft_rst)
            write_start_q <= 1'b0; // [R19]
         else if (op_done)
            write_start_q <= 1'b0; // [R13] [R21]
         else if (start_op)
            write_start_q <= 1'b1; // [R13]
      end
   end

   // write permit and operation select
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         write_permit_q     <= NVU_CONTROL_RST[NVU_WRITE_PERMIT_BIT]; // [R14]
         operation_select_q <= NVU_CONTROL_RST[NVU_OPSEL_W-1:0];
      end
      else if (clk_en)
      begin
         if (soft_rst)
         begin
            write_permit_q     <= 1'b0; // [R19]
            operation_select_q <= '0;
         end
         else if (wr_ctrl)
         begin
            write_permit_q <= sfr_wdata[NVU_WRITE_PERMIT_BIT];
            if (state_q == ST_IDLE)
               operation_select_q <= sfr_wdata[NVU_OPSEL_W-1:0];
         end
      end
   end

   // abort error: set when a reset cause hits a running operation
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         write_abort_error_q <= NVU_CONTROL_RST[NVU_WRITE_ABORT_ERROR_BIT];
      else if (clk_en)
      begin
         if (soft_rst)
            write_abort_error_q <= (state_q != ST_IDLE); // [R15] [R19]
         else if (wr_ctrl)
            write_abort_error_q <= sfr_wdata[NVU_WRITE_ABORT_ERROR_BIT];
      end
   end

   // operation parameters latched at start
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         op_erase_q <= 1'b0;
         op_block_q <= 1'b0;
         op_idx_q   <= '0;
      end
      else if (start_op)
      begin
         op_erase_q <= sfr_wdata[NVU_OP_ERASE_BIT];
         op_block_q <= (new_target == NVU_OP_EE_BLOCK); // [R6]
         op_idx_q   <= nvu_ee_idx(target_ea); // [R7]
      end
   end

   // address registers: no reset so a cut write can be retried
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         if (tbl_valid)
         begin
            addr_low_q   <= tbl_ea[15:0]; // [R22] [R16]
            addr_upper_q <= tbl_ea[23:16]; // [R22]
         end
         else
         begin
            if (wr_low)
               addr_low_q <= sfr_wdata;
            if (wr_upper)
               addr_upper_q <= sfr_wdata[7:0];
         end
      end
   end

   // write latches loaded by table write low to the eeprom window
   always_ff @(posedge ref_clk)
   begin
      if (clk_en && tbl_valid && tbl_write && tbl_ee_hit)
         ee_latch[tbl_idx[NVU_BLK_W-1:0]] <= tbl_wdata; // [R18]
   end

   // eeprom array update at the end of an eeprom operation
   always_ff @(posedge ref_clk)
   begin
      if (op_done && state_q == ST_EE_BUSY)
      begin
         for (int i = 0; i < NVU_BLK_WORDS; i++)
         begin
            if (op_block_q ||
                NVU_BLK_W'(i) == op_idx_q[NVU_BLK_W-1:0])
               ee_mem[{op_idx_q[NVU_EE_IDX_W-1:NVU_BLK_W],
                       NVU_BLK_W'(i)}] <=
                  op_erase_q ? NVU_ERASED : ee_latch[i]; // [R6]
         end
      end
   end

   // done flag: sticky, a new completion beats a clear
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         done_flag_q <= 1'b0;
      else if (clk_en)
      begin
         if (op_done)
            done_flag_q <= 1'b1; // [R17]
         else if (memory_op_done_clear)
            done_flag_q <= 1'b0; // [R17]
      end
   end

   // table read low of the eeprom, zero while eeprom busy or outside it
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tbl_rdata_q  <= 16'h0000;
         tbl_rvalid_q <= 1'b0;
      end
      else if (clk_en)
      begin
         tbl_rvalid_q <= tbl_valid && !tbl_write;
         if (tbl_valid && !tbl_write)
         begin
            if (tbl_ee_hit && state_q != ST_EE_BUSY)
               tbl_rdata_q <= ee_mem[tbl_idx]; // [R18]
            else
               tbl_rdata_q <= 16'h0000; // [R12]
         end
      end
   end

   // register read mux, key register reads as zero
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         sfr_rdata_q <= 16'h0000;
      else if (clk_en && sfr_rd_en)
      begin
         unique case (sfr_addr)
            NVU_CONTROL_OFS:
               sfr_rdata_q <= {write_start_q, write_permit_q,
                               write_abort_error_q, 6'h00,
                               operation_select_q};
            NVU_ADDR_LOW_OFS:   sfr_rdata_q <= addr_low_q;
            NVU_ADDR_UPPER_OFS: sfr_rdata_q <= {NVU_UPPER_HI, addr_upper_q};
            default:            sfr_rdata_q <= 16'h0000;
         endcase
      end
   end

   // outputs
   assign sfr_rdata           = sfr_rdata_q;
   assign tbl_rdata           = tbl_rdata_q;
   assign tbl_rvalid          = tbl_rvalid_q;
   assign memory_op_done_flag = done_flag_q;
   assign cpu_stall           = (state_q == ST_FL_BUSY); // [R21] [R10]

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_start_needs_key: assert property ( // [R1]
      $rose(write_start_q) |-> $past(unlock_ok))
      else $error("operation started without unlock");
   a_wr_sticky_sw: assert property ( // [R13]
      write_start_q && clk_en && !op_done && !soft_rst |=> write_start_q)
      else $error("write start cleared early");
   a_permit_gates: assert property ( // [R14]
      $rose(write_start_q) |-> $past(sfr_wdata[NVU_WRITE_PERMIT_BIT] && wr_ctrl))
      else $error("start without write permit");
   a_abort_error: assert property ( // [R15]
      soft_rst && clk_en && state_q != ST_IDLE |=>
      write_abort_error_q && !write_start_q && state_q == ST_IDLE)
      else $error("abort not flagged");
   a_done_flag_set: assert property ( // [R17]
      op_done |=> memory_op_done_flag && !write_start_q)
      else $error("done flag not set");
   a_ee_no_stall: assert property ( // [R10]
      state_q == ST_EE_BUSY |-> !cpu_stall && write_start_q)
      else $error("eeprom operation stalls core");
   a_flash_stall: assert property ( // [R21]
      state_q == ST_FL_BUSY |-> cpu_stall && write_start_q)
      else $error("flash operation does not stall");
   a_addr_capture: assert property ( // [R22]
      tbl_valid && clk_en |=> addr_low_q == $past(tbl_ea[15:0]) &&
      addr_upper_q == $past(tbl_ea[23:16]))
      else $error("table address not captured");
   a_read_outside: assert property ( // [R5]
      tbl_valid && !tbl_write && clk_en && !tbl_ee_hit |=>
      tbl_rvalid && tbl_rdata == 16'h0000)
      else $error("read outside eeprom not zero");
   a_reset_clears: assert property ( // [R19]
      soft_rst && clk_en |=> !write_permit_q && operation_select_q == '0)
      else $error("control not cleared by reset");

   c_ee_start: cover property (start_op && !new_is_flash);
   c_fl_start: cover property (start_op && new_is_flash);
   c_abort: cover property (soft_rst && state_q != ST_IDLE);
   c_done_clear: cover property (op_done && memory_op_done_clear);
endmodule

// File: testbench/nvu_core_model.sv
/*
 nvu_core_model: processor core side of nvu_ctrl, one register or
 table access at a time. Assumes a running ref_clk and idle strobes.
*/
`timescale 1ns/10ps
module nvu_core_model
   import nvu_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic [15:0] sfr_rdata,
   input  wire logic [15:0] tbl_rdata,
   input  wire logic        tbl_rvalid,
   output logic      [15:0] sfr_addr,
   output logic             sfr_wr_en,
   output logic             sfr_rd_en,
   output logic      [15:0] sfr_wdata,
   output logic             tbl_valid,
   output logic             tbl_write,
   output logic      [23:0] tbl_ea,
   output logic      [15:0] tbl_wdata
);
   // quiet bus at time zero
   initial
   begin
      sfr_addr = 16'h0000;
      sfr_wr_en = 1'b0;
      sfr_rd_en = 1'b0;
      sfr_wdata = 16'h0000;
      tbl_valid = 1'b0;
      tbl_write = 1'b0;
      tbl_ea = 24'h000000;
      tbl_wdata = 16'h0000;
   end

   // release strobes, released data shows its inverse
   task automatic drop();
      sfr_wr_en <= 1'b0;
      sfr_rd_en <= 1'b0;
      tbl_valid <= 1'b0;
      sfr_wdata <= ~sfr_wdata;
      tbl_wdata <= ~tbl_wdata;
   endtask

   // one register access, read data taken after the edge
   task automatic sfr(input logic w, input logic [15:0] a, d,
                      output logic [15:0] q);
      @(posedge ref_clk);
      sfr_wr_en <= w;
      sfr_rd_en <= !w;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge ref_clk);
      drop();
      #1 q = sfr_rdata;
   endtask

   // one table access, no valid means unknown data
   task automatic tbl(input logic w, input logic [23:0] a,
                      input logic [15:0] d, output logic [15:0] q);
      @(posedge ref_clk);
      tbl_valid <= 1'b1;
      tbl_write <= w;
      tbl_ea <= a;
      tbl_wdata <= d;
      @(posedge ref_clk);
      drop();
      #1 q = tbl_rvalid ? tbl_rdata : 16'hxxxx;
   endtask

   // keys then start, brk puts an upper address write between the two keys
   task automatic start_op(input logic [15:0] c, input logic brk);
      logic [15:0] q;
      sfr(1'b1, NVU_KEY_OFS, {8'h00, NVU_KEY_FIRST}, q);
      if (brk)
         sfr(1'b1, NVU_ADDR_UPPER_OFS, 16'h007f, q);
      sfr(1'b1, NVU_KEY_OFS, {8'h00, NVU_KEY_SECOND}, q);
      sfr(1'b1, NVU_CONTROL_OFS, c, q);
      repeat (2) @(posedge ref_clk);
   endtask
endmodule

// File: testbench/tb_top.sv
/*
 tb_top: register and table sequences against nvu_ctrl.
 Assumes the core model and 20-cycle operations.
*/
`timescale 1ns/10ps
module tb_top
   import nvu_pkg::*;
;
   localparam int          CYC = 20;
   localparam logic [15:0] CTL = NVU_CONTROL_OFS;
   localparam logic [15:0] ALO = NVU_ADDR_LOW_OFS;
   localparam logic [15:0] AUP = NVU_ADDR_UPPER_OFS;
   logic        ref_clk, resetn, clk_en, done_clr, mc_rst, wd_rst;
   logic        sfr_wr_en, sfr_rd_en, tbl_valid, tbl_write, tbl_rvalid;
   logic        done_flag, stall;
   logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, tbl_wdata, tbl_rdata, q;
   logic [23:0] tbl_ea;
   int          n_fail = 0;
   int          tests_run = 0;
   int          cyc = 0;

   nvu_ctrl #(.EE_WRITE_CYCLES(CYC), .FL_WRITE_CYCLES(CYC)) i_nvu_ctrl (
      .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
      .master_clear_reset(mc_rst), .watchdog_timer_timeout(wd_rst),
      .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .tbl_valid(tbl_valid), .tbl_write(tbl_write), .tbl_ea(tbl_ea),
      .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata),
      .tbl_rvalid(tbl_rvalid), .memory_op_done_clear(done_clr),
      .memory_op_done_flag(done_flag), .cpu_stall(stall));
   nvu_core_model i_nvu_core_model (
      .ref_clk(ref_clk), .sfr_rdata(sfr_rdata), .tbl_rdata(tbl_rdata),
      .tbl_rvalid(tbl_rvalid), .sfr_addr(sfr_addr),
      .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
      .sfr_wdata(sfr_wdata), .tbl_valid(tbl_valid),
      .tbl_write(tbl_write), .tbl_ea(tbl_ea), .tbl_wdata(tbl_wdata));

   // 100 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      $display("counts: %0d checks, %0d wrong", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic rd(input logic [15:0] a);
      i_nvu_core_model.sfr(1'b0, a, 16'h0000, q);
   endtask

   task automatic wr(input logic [15:0] a, d);
      logic [15:0] x;
      i_nvu_core_model.sfr(1'b1, a, d, x);
   endtask

   task automatic tb(input logic w, input logic [23:0] a,
                     input logic [15:0] d);
      i_nvu_core_model.tbl(w, a, d, q);
   endtask

   // one reset-cause pulse
   task automatic cause(input int k);
      @(posedge ref_clk);
      mc_rst <= (k == 0);
      wd_rst <= (k == 1);
      @(posedge ref_clk);
      mc_rst <= 1'b0;
      wd_rst <= 1'b0;
   endtask

   // run one operation to its end and acknowledge the done flag
   task automatic op(input logic [15:0] c);
      int   n;
      logic fl;
      fl = (c[3:0] == NVU_OP_FLASH_ROW);
      i_nvu_core_model.start_op(c, 1'b0);
      #1 chk(16'(stall), 16'(fl));
      if (!fl)
      begin
         wr(CTL, c & 16'h7fff);
         rd(CTL);
         chk(q, c);
      end
      n = 0;
      while (done_flag !== 1'b1 && n < 4 * CYC)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk(16'(n > CYC - 8 && n <= CYC + 1), 16'h0001);
      chk(16'(stall), 16'h0000);
      rd(CTL);
      chk(q, c & 16'h7fff);
      repeat (3) @(posedge ref_clk);
      #1 chk(16'(done_flag), 16'h0001);
      @(posedge ref_clk);
      done_clr <= 1'b1;
      @(posedge ref_clk);
      done_clr <= 1'b0;
      #1 chk(16'(done_flag), 16'h0000);
   endtask

   // hang guard
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         $display("wrong value at %0t: run timed out", $time);
         conclude();
      end
   end

   // main sequence
   initial
   begin
      resetn = 1'b0;
      clk_en = 1'b1;
      done_clr = 1'b0;
      mc_rst = 1'b0;
      wd_rst = 1'b0;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(CTL);
      chk(q, NVU_CONTROL_RST);
      rd(NVU_KEY_OFS);
      chk(q, 16'h0000);
      rd(AUP);
      chk(q & 16'hff00, {NVU_UPPER_HI, 8'h00});
      $display("test reset values done");
      tb(1'b1, NVU_EE_LAST, 16'h1234);
      rd(ALO);
      chk(q, 16'hfffe);
      rd(AUP);
      chk(q, 16'h007f);
      op(16'hc044);
      tb(1'b0, NVU_EE_LAST, 16'h0000);
      chk(q, NVU_ERASED);
      tb(1'b1, NVU_EE_LAST, 16'h1234);
      op(16'hc004);
      tb(1'b0, NVU_EE_LAST, 16'h0000);
      chk(q, 16'h1234);
      tb(1'b0, NVU_EE_BASE - 24'h2, 16'h0000);
      chk(q, 16'h0000);
      $display("test word done");
      wr(AUP, 16'h007f);
      wr(ALO, 16'hfc40);
      op(16'hc045);
      tb(1'b0, NVU_EE_BASE + 24'h5e, 16'h0000);
      chk(q, NVU_ERASED);
      for (int i = 0; i < NVU_BLK_WORDS; i++)
         tb(1'b1, NVU_EE_BASE + 24'h40 + 24'(2 * i), 16'ha500 + 16'(i));
      op(16'hc005);
      for (int i = 0; i < NVU_BLK_WORDS; i++)
      begin
         tb(1'b0, NVU_EE_BASE + 24'h40 + 24'(2 * i), 16'h0000);
         chk(q, 16'ha500 + 16'(i));
      end
      $display("test block done");
      for (int k = 0; k < 3; k++)
      begin
         if (k == 0)
            wr(CTL, 16'hc004);
         else
            i_nvu_core_model.start_op(k == 1 ? 16'hc004 : 16'h8004, k == 1);
         rd(CTL);
         chk(q & 16'h8000, 16'h0000);
      end
      $display("test refused starts done");
      wr(AUP, 16'h0000);
      wr(ALO, 16'h0100);
      op(16'hc001);
      $display("test flash row done");
      for (int k = 0; k < 2; k++)
      begin
         wr(AUP, 16'h007f);
         wr(ALO, 16'hfc60);
         i_nvu_core_model.start_op(16'hc044, 1'b0);
         tb(1'b0, NVU_EE_BASE + 24'h60, 16'h0000);
         cause(k);
         rd(CTL);
         chk(q, 16'h2000);
         rd(ALO);
         chk(q, 16'hfc60);
         cause(k);
         rd(CTL);
         chk(q, NVU_CONTROL_RST);
      end
      $display("test aborted write done");
      conclude();
   end
endmodule
